//--- verilog/pps_pkg.sv
// Constants, types and timing counts for the pushbutton power sequencer.
// Assumes a single 25 MHz system clock and synchronous inputs.
// Summary of operation
// - Reset leaves power enable released
// - Turn-on needs continuous 32 ms low press
// - Turn-off needs continuous 32 ms low press
// - Ignore force-off for 512 ms after enable
// - Force-off low at blanking end releases enable
// - After blanking, force-off low releases enable
// - Qualified turn-off press drives shutdown request low
// - 1024 ms power-down timer then release
// - Enable polarity is a build option
// - Button release restarts the debounce timer
// - Button ignored during blanking interval
// - 256 ms button lockout after force-off release, except at blanking end
// - Force-off low must last 30 us
package pps_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_US = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned DB_ON_MS = 32;
  localparam int unsigned DB_OFF_MS = 32;
  localparam int unsigned BLANK_MS = 512;
  localparam int unsigned PDOWN_MS = 1024;
  localparam int unsigned LOCK_MS = 256;
  localparam int unsigned FOFF_MIN_US = 30;
  localparam int unsigned EXT_STEP_MS = 1;
  localparam int unsigned DB_ON_TICKS = DB_ON_MS * 1000 / TICK_US;
  localparam int unsigned DB_OFF_TICKS = DB_OFF_MS * 1000 / TICK_US;
  localparam int unsigned BLANK_TICKS = BLANK_MS * 1000 / TICK_US;
  localparam int unsigned PDOWN_TICKS = PDOWN_MS * 1000 / TICK_US;
  localparam int unsigned LOCK_TICKS = LOCK_MS * 1000 / TICK_US;
  localparam int unsigned EXT_TICKS = EXT_STEP_MS * 1000 / TICK_US;
  localparam int unsigned FOFF_TICKS = (FOFF_MIN_US + TICK_US - 1) / TICK_US;
  localparam int unsigned TW = 21;
  localparam int unsigned EW = 8;

  typedef enum logic [2:0] {
    PPS_OFF = 3'b000,
    PPS_ON_DB = 3'b001,
    PPS_BLANK = 3'b011,
    PPS_RUN = 3'b010,
    PPS_OFF_DB = 3'b110,
    PPS_PDOWN = 3'b111,
    PPS_LOCK = 3'b101,
    PPS_REL = 3'b100
  } pps_state_t;

  typedef struct packed {
    logic power_enable;
    logic shutdown_request_n;
  } pps_out_t;
endpackage

//--- verilog/pps_tick.sv
// Time base divider for the pushbutton power sequencer.
// Assumes clk_sys at the package rate; emits a one-cycle tick pulse.
`timescale 1ns/10ps
module pps_tick
  import pps_pkg::*;
#(
  parameter int unsigned DIV = TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  output logic tick
);
  logic [7:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  always_comb begin
    tick_d = 1'b0;
    cnt_d = cnt_q + 8'h01;
    if (cnt_q == 8'(DIV - 1)) begin
      cnt_d = 8'h00;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule

//--- verilog/pps_top.sv
// Pushbutton on/off sequencer: debounce, blanking, power-down, lockout.
// Assumes synchronous, already-clean digital levels on all inputs.
`timescale 1ns/10ps
module pps_top
  import pps_pkg::*;
#(
  parameter bit EN_ACTIVE_HIGH = 1'b1,
  parameter int unsigned DB_ON = DB_ON_TICKS,
  parameter int unsigned DB_OFF = DB_OFF_TICKS,
  parameter int unsigned BLANK = BLANK_TICKS,
  parameter int unsigned PDOWN = PDOWN_TICKS,
  parameter int unsigned LOCK = LOCK_TICKS,
  parameter int unsigned EXT_STEP = EXT_TICKS,
  parameter int unsigned FOFF_MIN = FOFF_TICKS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic push_button_n,
  input wire logic force_off_n,
  input wire logic [EW-1:0] on_time_extend,
  input wire logic [EW-1:0] off_time_extend,
  output logic power_enable,
  output logic shutdown_request_n,
  output logic powered_on
);
  ////////////////////////////////////////////////////////////////////////////
  logic tick;
  pps_state_t st_q, st_d;
  logic [TW-1:0] tmr_q, tmr_d;
  logic [5:0] foff_q, foff_d;
  logic pb_q, pb_d;
  pps_out_t out_q, out_d;
  logic on_q, on_d;
  logic foff_low;

  // Qualification time: default plus extension steps, in ticks
  function automatic logic [TW-1:0] qual(input int unsigned base,
                                        input logic [EW-1:0] ext);
    qual = TW'(base) + TW'(ext) * TW'(EXT_STEP);
  endfunction

  pps_tick u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Glitch filter: short low pulses reach the sequencer only through the raw check at blanking end
  always_comb begin
    foff_d = foff_q;
    if (force_off_n) begin
      foff_d = 6'h00;
    end else if (tick && foff_q != 6'(FOFF_MIN)) begin
      foff_d = foff_q + 6'h01;
    end
  end
  assign foff_low = (foff_q == 6'(FOFF_MIN));

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    pb_d = push_button_n;
    out_d = out_q;
    case (st_q)
      PPS_OFF: begin
        out_d.power_enable = 1'b0;
        out_d.shutdown_request_n = 1'b1;
        tmr_d = '0;
        if (pb_q && !push_button_n) begin
          st_d = PPS_ON_DB;
        end
      end
      PPS_ON_DB: begin
        if (push_button_n) begin
          st_d = PPS_OFF;
        end else if (tick) begin
          tmr_d = tmr_q + 1'b1;
          if (tmr_q + 1'b1 >= qual(DB_ON, on_time_extend)) begin
            st_d = PPS_BLANK;
            tmr_d = '0;
            out_d.power_enable = 1'b1;
          end
        end
      end
      PPS_BLANK: begin
        // Button ignored and force-off read only at the final tick, so power-up cannot be interrupted
        if (tick) begin
          tmr_d = tmr_q + 1'b1;
          if (tmr_q + 1'b1 >= TW'(BLANK)) begin
            tmr_d = '0;
            if (!force_off_n) begin
              st_d = PPS_REL;
              out_d.power_enable = 1'b0;
            end else begin
              st_d = PPS_RUN;
            end
          end
        end
      end
      PPS_RUN: begin
        tmr_d = '0;
        if (foff_low) begin
          st_d = PPS_LOCK;
          out_d.power_enable = 1'b0;
        end else if (!push_button_n) begin
          st_d = PPS_OFF_DB;
        end
      end
      PPS_OFF_DB: begin
        if (foff_low) begin
          st_d = PPS_LOCK;
          tmr_d = '0;
          out_d.power_enable = 1'b0;
        end else if (push_button_n) begin
          st_d = PPS_RUN;
        end else if (tick) begin
          tmr_d = tmr_q + 1'b1;
          if (tmr_q + 1'b1 >= qual(DB_OFF, off_time_extend)) begin
            st_d = PPS_PDOWN;
            tmr_d = '0;
            out_d.shutdown_request_n = 1'b0;
          end
        end
      end
      PPS_PDOWN: begin
        if (foff_low) begin
          st_d = PPS_LOCK;
          tmr_d = '0;
          out_d.power_enable = 1'b0;
          out_d.shutdown_request_n = 1'b1;
        end else if (tick) begin
          tmr_d = tmr_q + 1'b1;
          if (tmr_q + 1'b1 >= TW'(PDOWN)) begin
            st_d = PPS_REL;
            tmr_d = '0;
            out_d.power_enable = 1'b0;
            out_d.shutdown_request_n = 1'b1;
          end
        end
      end
      PPS_LOCK: begin
        // Converter output decays before any restart is allowed
        out_d.shutdown_request_n = 1'b1;
        if (tick) begin
          tmr_d = tmr_q + 1'b1;
          if (tmr_q + 1'b1 >= TW'(LOCK)) begin
            st_d = PPS_REL;
          end
        end
      end
      PPS_REL: begin
        // Wait for button release so a held press does not restart
        out_d.shutdown_request_n = 1'b1;
        if (push_button_n) begin
          st_d = PPS_OFF;
        end
      end
      default: begin
        st_d = PPS_OFF;
        out_d.power_enable = 1'b0;
        out_d.shutdown_request_n = 1'b1;
      end
    endcase
    on_d = out_d.power_enable;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= PPS_OFF;
      tmr_q <= '0;
      foff_q <= 6'h00;
      pb_q <= 1'b1;
      out_q <= '{power_enable: 1'b0, shutdown_request_n: 1'b1};
      on_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      foff_q <= foff_d;
      pb_q <= pb_d;
      out_q <= out_d;
      on_q <= on_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Polarity fixed at build time; pin level = logical state xnor variant
  logic pen_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pen_q <= ~EN_ACTIVE_HIGH;
    end else begin
      pen_q <= out_d.power_enable ~^ EN_ACTIVE_HIGH;
    end
  end

  assign power_enable = pen_q;
  assign shutdown_request_n = out_q.shutdown_request_n;
  assign powered_on = on_q;
endmodule

//--- testbench/pps_chk_sva.sv
// Checker on the sequencer top: timing relations seen at its ports.
// Assumes 25 clocks per tick and the counts handed on by the bind.
`timescale 1ns/10ps
module pps_chk
  import pps_pkg::*;
#(
  parameter bit EN_ACTIVE_HIGH = 1'b1,
  parameter int unsigned DB_ON = DB_ON_TICKS,
  parameter int unsigned DB_OFF = DB_OFF_TICKS,
  parameter int unsigned BLANK = BLANK_TICKS,
  parameter int unsigned PDOWN = PDOWN_TICKS,
  parameter int unsigned FOFF_MIN = FOFF_TICKS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic push_button_n,
  input wire logic force_off_n,
  input wire logic power_enable,
  input wire logic shutdown_request_n,
  input wire logic powered_on
);
  logic [31:0] lo_q, on_q, fo_q, sr_q, lo_d, on_d, fo_d, sr_d;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  always_comb begin
    lo_d = push_button_n ? 32'h0 : lo_q + 32'h1;
    on_d = powered_on ? on_q + 32'h1 : 32'h0;
    fo_d = force_off_n ? 32'h0 : fo_q + 32'h1;
    sr_d = shutdown_request_n ? 32'h0 : sr_q + 32'h1;
  end
  always_ff @(posedge clk_sys) begin
    lo_q <= rst ? 32'h0 : lo_d;
    on_q <= rst ? 32'h0 : on_d;
    fo_q <= rst ? 32'h0 : fo_d;
    sr_q <= rst ? 32'h0 : sr_d;
  end
  ////////////////////////////////////////
  chk_reset_off: assert property (disable iff (1'b0)
    rst |=> !powered_on && shutdown_request_n) else $error("on in reset");
  chk_en_polarity: assert property (
    power_enable == (powered_on ~^ EN_ACTIVE_HIGH)) else $error("polarity");
  chk_on_press: assert property (
    $rose(powered_on) |-> lo_q >= (DB_ON - 1) * TICK_CYC) else $error("on");
  chk_off_press: assert property (
    $fell(shutdown_request_n) |-> powered_on
      && lo_q >= (DB_OFF - 1) * TICK_CYC) else $error("off press");
  chk_blank_hold: assert property (
    $fell(powered_on) |-> on_q >= (BLANK - 1) * TICK_CYC) else $error("blank");
  chk_force_release: assert property (
    !(fo_q > (FOFF_MIN + 1) * TICK_CYC + 10
      && on_q > (BLANK + 1) * TICK_CYC + 10)) else $error("force ignored");
  chk_glitch_reject: assert property (
    // Power-down exits excluded: a timeout release sees force-off high
    $fell(powered_on) && shutdown_request_n && $past(shutdown_request_n)
      && on_q > (BLANK + 2) * TICK_CYC
      |-> fo_q >= (FOFF_MIN - 1) * TICK_CYC) else $error("glitch");
  chk_request_free: assert property (
    $fell(powered_on) |-> ##[0:2] shutdown_request_n) else $error("request");
  chk_pdown_max: assert property (
    sr_q <= (PDOWN + 1) * TICK_CYC + 5) else $error("power-down late");
  cover property ($rose(powered_on));
  cover property ($fell(shutdown_request_n));
  cover property ($fell(powered_on) && shutdown_request_n);
endmodule
bind pps_top pps_chk #(.EN_ACTIVE_HIGH(EN_ACTIVE_HIGH), .DB_ON(DB_ON),
  .DB_OFF(DB_OFF), .BLANK(BLANK), .PDOWN(PDOWN), .FOFF_MIN(FOFF_MIN)) u_chk (
  .clk_sys, .rst, .push_button_n, .force_off_n, .power_enable,
  .shutdown_request_n, .powered_on);

//--- testbench/pps_host_model.sv
// Host model: processor end of the force-off and shutdown handshake.
// Assumes powered_on tells whether the host has supply.
`timescale 1ns/10ps
module pps_host_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic powered_on,
  input wire logic shutdown_request_n,
  input wire logic [2:0] mode,
  output logic force_off_n
);
  // Modes: 0 prompt, 1 never ready, 2 ignores request, 3 request tied,
  // 4 forces off, 5 short glitch
  int cnt = 0;
  int hk = 0;
  always @(posedge clk_sys) begin
    cnt <= cnt + 1;
    hk <= shutdown_request_n ? 0 : hk + 1;
    if (rst || !powered_on) begin
      // An unpowered host cannot hold the line high
      force_off_n <= 1'b0;
      cnt <= 0;
    end else if (!shutdown_request_n) begin
      if (mode == 3'h3 || (mode == 3'h0 && hk > 100))
        force_off_n <= 1'b0;
    end else begin
      force_off_n <= cnt > 200 && mode != 3'h1 && !(mode == 3'h4 && cnt > 700)
        && !(mode == 3'h5 && cnt > 700 && cnt < 740);
    end
  end
endmodule

//--- testbench/tb.sv
// Bench: button stimulus, host model and checks of the sequencer outputs.
// Assumes the shortened counts below, 25 clocks per tick.
`timescale 1ns/10ps
module tb;
  import pps_pkg::*;
  localparam logic [2:0] OFF = 3'h2, ON = 3'h7, SRQ = 3'h5;
  // Shortened debounce count and extension step shared by dut and thr
  localparam int unsigned DBQ = 5, STEP = 2;
  logic clk_sys = 0, rst = 1, push_button_n = 1;
  logic [2:0] mode = 3'h0;
  logic [EW-1:0] on_x = 8'h0, off_x = 8'h0;
  logic [31:0] seed = 32'h19;
  wire force_off_n, power_enable, shutdown_request_n, powered_on;
  wire [2:0] st = {power_enable, shutdown_request_n, powered_on};
  int n_errors = 0, n_compared = 0;
  always #20 clk_sys = ~clk_sys;
  pps_top #(.DB_ON(DBQ), .DB_OFF(DBQ), .BLANK(20), .PDOWN(30), .LOCK(10),
    .EXT_STEP(STEP), .FOFF_MIN(3)) dut (.clk_sys, .rst, .push_button_n,
    .force_off_n, .on_time_extend(on_x), .off_time_extend(off_x),
    .power_enable, .shutdown_request_n, .powered_on);
  pps_host_model host (.clk_sys, .rst, .powered_on, .shutdown_request_n,
    .mode, .force_off_n);
  ////////////////////////////////////////
  function automatic int thr(int x);
    return (DBQ + STEP * x) * TICK_CYC;
  endfunction
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(logic [2:0] seen, logic [2:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hold(int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic press(int n);
    @(posedge clk_sys);
    push_button_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    push_button_n <= 1'b1;
    @(negedge clk_sys);
  endtask
  // Short press first: the one-cycle release between presses must
  // restart the count, or the long press would qualify too early
  task automatic qual(bit off, logic [2:0] m, logic [2:0] pre, post);
    int x;
    x = rnd() % 4;
    @(posedge clk_sys);
    mode <= m;
    if (off) off_x <= EW'(x);
    else on_x <= EW'(x);
    press(thr(x) - 60);
    check(st, pre);
    // Short margin: a tied host releases power about three ticks later
    press(thr(x) + 40);
    check(st, post);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    hold(1);
    check(st, OFF);
    qual(0, 3'h0, OFF, ON);
    press(150);
    check(st, ON);
    hold(600);
    check(st, ON);
    qual(1, 3'h0, ON, SRQ);
    hold(600);
    check(st, OFF);
    $display("end: normal");
    qual(0, 3'h1, OFF, ON);
    hold(600);
    check(st, OFF);
    $display("end: abort");
    qual(0, 3'h4, OFF, ON);
    hold(800);
    check(st, OFF);
    press(thr(on_x) + 60);
    check(st, OFF);
    $display("end: forced off");
    qual(0, 3'h5, OFF, ON);
    hold(800);
    check(st, ON);
    qual(1, 3'h2, ON, SRQ);
    hold(680);
    check(st, SRQ);
    hold(80);
    check(st, OFF);
    $display("end: timeout");
    qual(0, 3'h3, OFF, ON);
    hold(600);
    qual(1, 3'h3, ON, SRQ);
    hold(100);
    check(st, OFF);
    $display("end: tied");
    summarize();
  end
  initial begin
    hold(40000);
    n_errors++;
    summarize();
  end
endmodule
